// >>> core/sdmc_ctrl.sv
// Operation
// - command 10h puts the device into its lowest-power sleep state
// - sleeping keeps converter, oscillator and panel scanning halted
// - sleeping keeps host interface and frame memory working, contents kept
// - no brightness dimming while going from awake into sleep
// - sleep command while sleeping does nothing; only 11h leaves sleep
// - command 11h wakes: converter on, oscillator started, scanning resumed
// - wake command while awake does nothing; only 10h or the 01h software reset leaves awake
// - accepting the wake command runs the self-diagnostic
// - wake order: oscillator, converter, offset charge, then awake
// - two blank frames follow oscillator start, whatever display on/off says
// - after the blank frames the frame memory is shown
// - command 12h turns partial display mode on
// - partial-on command does nothing while partial mode is active
// - command 13h selects normal full-screen display, clearing partial mode
// - normal-mode command does nothing while normal mode is active
// - read command 0Fh returns load-detect and checksum-mismatch bits
`timescale 1ns/1ns
module sdmc_ctrl
    import sdmc_pkg::*;
#(
    parameter logic [SEQ_TIMER_W-1:0] OSC_START_CYC     = SEQ_OSC_START_CYC,
    parameter logic [SEQ_TIMER_W-1:0] DCDC_START_CYC    = SEQ_DCDC_START_CYC,
    parameter logic [SEQ_TIMER_W-1:0] OFFSET_CHARGE_CYC =
        SEQ_OFFSET_CHARGE_CYC
) (
    input  wire logic            sys_clk_i,
    input  wire logic            resetn_i,
    input  wire sdmc_host_pins_t host_i,
    input  wire logic            frame_tick_i,
    input  wire logic            reg_load_detect_i,
    input  wire logic            checksum_mismatch_i,
    input  wire logic            dimming_req_i,
    output logic [7:0]           data_o,
    output logic                 data_oe_o,
    output sdmc_power_t          power_o,
    output logic                 blank_o,
    output logic                 show_mem_o,
    output logic                 partial_mode_o,
    output logic                 sleep_o,
    output logic                 diag_run_o,
    output logic                 dimming_en_o,
    output logic                 mem_if_en_o
);

    // captured host command
    logic                   cmd_valid;
    logic [7:0]             cmd_byte;
    logic                   sw_reset;

    // wake sequencing
    sdmc_state_t            state_r;
    sdmc_state_t            state_nxt;
    logic                   tmr_load;
    logic                   tmr_abort;
    logic [SEQ_TIMER_W-1:0] tmr_val;
    logic                   tmr_done;

    // display mode and frame state
    logic                   partial_r;
    logic                   partial_nxt;
    logic [1:0]             blank_cnt_r;
    logic [1:0]             blank_cnt_nxt;

    // self-diagnostic results
    logic                   load_flag_r;
    logic                   load_flag_nxt;
    logic                   cksum_flag_r;
    logic                   cksum_flag_nxt;
    logic [7:0]             diag_byte;

    // readback path
    logic                   rd_prev_r;
    logic                   rd_armed_r;
    logic                   rd_armed_nxt;
    logic                   rd_idx_r;
    logic                   rd_idx_nxt;
    logic [7:0]             data_r;
    logic [7:0]             data_nxt;
    logic                   data_oe_r;
    logic                   data_oe_nxt;

    // registered outputs
    sdmc_power_t            power_r;
    sdmc_power_t            power_nxt;
    logic                   blank_r;
    logic                   blank_nxt;
    logic                   show_mem_r;
    logic                   show_mem_nxt;
    logic                   diag_run_r;
    logic                   diag_run_nxt;
    logic                   dimming_r;
    logic                   dimming_nxt;
    logic                   mem_if_en_r;
    logic                   sleep_r;
    logic                   sleep_nxt;

    sdmc_cmd_capture u_cmd_capture (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .host_i      (host_i),
        .cmd_valid_o (cmd_valid),
        .cmd_byte_o  (cmd_byte)
    );

    sdmc_step_timer u_step_timer (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .load_i     (tmr_load),
        .abort_i    (tmr_abort),
        .load_val_i (tmr_val),
        .done_o     (tmr_done)
    );

    assign sw_reset = cmd_valid && sdmc_cmd_is(cmd_byte, CMD_SW_RESET);

    // power state machine; commands are decoded in every state, and
    // a sleep command during the wake sequence aborts it at once
    always_comb begin
        state_nxt = state_r;
        tmr_load  = 1'b0;
        tmr_abort = 1'b0;
        tmr_val   = OSC_START_CYC;
        if (sw_reset) begin
            state_nxt = ST_SLEEP;
            tmr_abort = 1'b1;
        end else if (cmd_valid &&
                     sdmc_cmd_is(cmd_byte, CMD_SLEEP_ENTRY)) begin
            // repeated sleep command leaves everything as it is
            if (state_r != ST_SLEEP) begin
                state_nxt = ST_SLEEP;
                tmr_abort = 1'b1;
            end
        end else if (cmd_valid &&
                     sdmc_cmd_is(cmd_byte, CMD_SLEEP_EXIT)) begin
            // wake only counts from sleep; awake it is ignored
            if (state_r == ST_SLEEP) begin
                state_nxt = ST_OSC_START;
                tmr_load  = 1'b1;
                tmr_val   = OSC_START_CYC;
            end
        end else if (tmr_done) begin
            case (state_r)
                ST_OSC_START: begin
                    state_nxt = ST_DCDC_START;
                    tmr_load  = 1'b1;
                    tmr_val   = DCDC_START_CYC;
                end
                ST_DCDC_START: begin
                    state_nxt = ST_OFFSET_CHARGE;
                    tmr_load  = 1'b1;
                    tmr_val   = OFFSET_CHARGE_CYC;
                end
                ST_OFFSET_CHARGE: begin
                    state_nxt = ST_AWAKE;
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_r <= ST_SLEEP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // partial/normal mode flag; setting an already set flag is harmless,
    // which is exactly the no-effect behaviour asked for
    always_comb begin
        partial_nxt = partial_r;
        if (sw_reset) begin
            partial_nxt = 1'b0;
        end else if (cmd_valid &&
                     sdmc_cmd_is(cmd_byte, CMD_PARTIAL_ON)) begin
            partial_nxt = 1'b1;
        end else if (cmd_valid &&
                     sdmc_cmd_is(cmd_byte, CMD_FULL_SCREEN)) begin
            partial_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            partial_r <= 1'b0;
        end else begin
            partial_r <= partial_nxt;
        end
    end

    // blank-frame counter armed when the oscillator starts; frame ticks
    // are ignored in sleep, where it is held at zero whenever the next state is sleep
    always_comb begin
        blank_cnt_nxt = blank_cnt_r;
        if (state_nxt == ST_SLEEP) begin
            blank_cnt_nxt = 2'h0;
        end else if (state_r == ST_SLEEP) begin
            blank_cnt_nxt = BLANK_FRAMES;
        end else if (frame_tick_i && blank_cnt_r != 2'h0) begin
            blank_cnt_nxt = blank_cnt_r - 2'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            blank_cnt_r <= 2'h0;
        end else begin
            blank_cnt_r <= blank_cnt_nxt;
        end
    end

    // diagnostic results latched when the wake sequence completes
    always_comb begin
        load_flag_nxt  = load_flag_r;
        cksum_flag_nxt = cksum_flag_r;
        if (sw_reset) begin
            load_flag_nxt  = 1'b0;
            cksum_flag_nxt = 1'b0;
        end else if (state_r == ST_OFFSET_CHARGE &&
                     state_nxt == ST_AWAKE) begin
            load_flag_nxt  = reg_load_detect_i;
            cksum_flag_nxt = checksum_mismatch_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            load_flag_r  <= 1'b0;
            cksum_flag_r <= 1'b0;
        end else begin
            load_flag_r  <= load_flag_nxt;
            cksum_flag_r <= cksum_flag_nxt;
        end
    end

    // readback byte: only the two diagnostic bits are ever set
    always_comb begin
        diag_byte                 = DIAG_RESET;
        diag_byte[DIAG_LOAD_BIT]  = load_flag_r;
        diag_byte[DIAG_CKSUM_BIT] = cksum_flag_r;
    end

    // readback: dummy byte first, then the result; the pins are
    // driven one cycle after the read strobe falls
    always_comb begin
        rd_armed_nxt = rd_armed_r;
        rd_idx_nxt   = rd_idx_r;
        if (cmd_valid) begin
            rd_armed_nxt = sdmc_cmd_is(cmd_byte, CMD_SELF_DIAG_RD);
            rd_idx_nxt   = 1'b0;
        end else if (rd_armed_r && !rd_prev_r && host_i.read_strobe_n) begin
            rd_idx_nxt = 1'b1;
            if (rd_idx_r) begin
                rd_armed_nxt = 1'b0;
            end
        end
        data_oe_nxt = rd_armed_r && !host_i.read_strobe_n &&
                      host_i.cmd_param_select;
        data_nxt    = rd_idx_r ? diag_byte : DUMMY_READ;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rd_prev_r  <= 1'b1;
            rd_armed_r <= 1'b0;
            rd_idx_r   <= 1'b0;
            data_r     <= 8'h00;
            data_oe_r  <= 1'b0;
        end else begin
            rd_prev_r  <= host_i.read_strobe_n;
            rd_armed_r <= rd_armed_nxt;
            rd_idx_r   <= rd_idx_nxt;
            data_r     <= data_nxt;
            data_oe_r  <= data_oe_nxt;
        end
    end

    // outputs follow the next state so they change with it, not after
    always_comb begin
        power_nxt               = POWER_OFF;
        power_nxt.osc_en        = state_nxt != ST_SLEEP;
        power_nxt.scan_en       = state_nxt != ST_SLEEP;
        power_nxt.dcdc_en       = state_nxt == ST_DCDC_START ||
                                  state_nxt == ST_OFFSET_CHARGE ||
                                  state_nxt == ST_AWAKE;
        power_nxt.offset_charge = state_nxt == ST_OFFSET_CHARGE;
        blank_nxt    = blank_cnt_nxt != 2'h0;
        show_mem_nxt = state_nxt != ST_SLEEP &&
                       state_nxt != ST_OSC_START &&
                       blank_cnt_nxt == 2'h0;
        diag_run_nxt = state_nxt == ST_OSC_START ||
                       state_nxt == ST_DCDC_START ||
                       state_nxt == ST_OFFSET_CHARGE;
        // dimming drops with the sleep command, never ramps into sleep
        dimming_nxt  = dimming_req_i && state_nxt == ST_AWAKE;
        // sleep flag kept in its own flop so the pin is glitch free
        sleep_nxt    = state_nxt == ST_SLEEP;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            power_r     <= POWER_OFF;
            blank_r     <= 1'b0;
            show_mem_r  <= 1'b0;
            diag_run_r  <= 1'b0;
            dimming_r   <= 1'b0;
            mem_if_en_r <= 1'b0;
            sleep_r     <= 1'b1;
        end else begin
            power_r     <= power_nxt;
            blank_r     <= blank_nxt;
            show_mem_r  <= show_mem_nxt;
            diag_run_r  <= diag_run_nxt;
            dimming_r   <= dimming_nxt;
            mem_if_en_r <= 1'b1;
            sleep_r     <= sleep_nxt;
        end
    end

    assign data_o         = data_r;
    assign data_oe_o      = data_oe_r;
    assign power_o        = power_r;
    assign blank_o        = blank_r;
    assign show_mem_o     = show_mem_r;
    assign partial_mode_o = partial_r;
    assign sleep_o        = sleep_r;
    assign diag_run_o     = diag_run_r;
    assign dimming_en_o   = dimming_r;
    assign mem_if_en_o    = mem_if_en_r;

endmodule : sdmc_ctrl

// >>> core/sdmc_pkg.sv
package sdmc_pkg;

    // command codes seen on the host write port
    localparam logic [7:0] CMD_SW_RESET      = 8'h01;
    localparam logic [7:0] CMD_SELF_DIAG_RD  = 8'h0F;
    localparam logic [7:0] CMD_SLEEP_ENTRY   = 8'h10;
    localparam logic [7:0] CMD_SLEEP_EXIT    = 8'h11;
    localparam logic [7:0] CMD_PARTIAL_ON    = 8'h12;
    localparam logic [7:0] CMD_FULL_SCREEN   = 8'h13;

    // clock rate and derived cycles per microsecond
    localparam int unsigned CLK_FREQ_KHZ   = 25000;
    localparam int unsigned CLK_CYC_PER_US = CLK_FREQ_KHZ / 1000;

    // host-side spacing, kept by the host, not checked here
    localparam int unsigned HOST_CMD_WAIT_MS   = 5;
    localparam int unsigned WAKE_TO_SLEEP_MS   = 120;

    // wake sequence step times, sum stays inside the host wait
    localparam int unsigned SEQ_OSC_START_US     = 1000;
    localparam int unsigned SEQ_DCDC_START_US    = 2000;
    localparam int unsigned SEQ_OFFSET_CHARGE_US = 1500;

    localparam int unsigned SEQ_TIMER_W = 20;
    localparam logic [SEQ_TIMER_W-1:0] SEQ_OSC_START_CYC =
        SEQ_TIMER_W'(SEQ_OSC_START_US * CLK_CYC_PER_US);
    localparam logic [SEQ_TIMER_W-1:0] SEQ_DCDC_START_CYC =
        SEQ_TIMER_W'(SEQ_DCDC_START_US * CLK_CYC_PER_US);
    localparam logic [SEQ_TIMER_W-1:0] SEQ_OFFSET_CHARGE_CYC =
        SEQ_TIMER_W'(SEQ_OFFSET_CHARGE_US * CLK_CYC_PER_US);

    // blank frames shown after the oscillator starts
    localparam logic [1:0] BLANK_FRAMES = 2'h2;

    // self-diagnostic readback byte layout
    localparam int unsigned DIAG_LOAD_BIT  = 7;
    localparam int unsigned DIAG_CKSUM_BIT = 0;
    localparam logic [7:0]  DIAG_RESET     = 8'h00;
    localparam logic [7:0]  DUMMY_READ     = 8'h00;

    typedef struct packed {
        logic       cmd_param_select;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic [7:0] data;
    } sdmc_host_pins_t;

    typedef struct packed {
        logic osc_en;
        logic dcdc_en;
        logic offset_charge;
        logic scan_en;
    } sdmc_power_t;

    localparam sdmc_power_t POWER_OFF = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_OSC_START,
        ST_DCDC_START,
        ST_OFFSET_CHARGE,
        ST_AWAKE
    } sdmc_state_t;

    // true when a captured command byte carries the given code
    function automatic logic sdmc_cmd_is(input logic [7:0] cmd_byte,
                                         input logic [7:0] code);
        return cmd_byte == code;
    endfunction : sdmc_cmd_is

endpackage : sdmc_pkg

// >>> core/sdmc_cmd_capture.sv
`timescale 1ns/1ns
module sdmc_cmd_capture
    import sdmc_pkg::*;
(
    input  wire logic            sys_clk_i,
    input  wire logic            resetn_i,
    input  wire sdmc_host_pins_t host_i,
    output logic                 cmd_valid_o,
    output logic [7:0]           cmd_byte_o
);

    logic       wr_prev_r;
    logic       wr_prev_nxt;
    logic       cmd_valid_r;
    logic       cmd_valid_nxt;
    logic [7:0] cmd_byte_r;
    logic [7:0] cmd_byte_nxt;

    // byte taken on the strobe's rising edge with select low;
    // parameter writes are ignored since no command here has any
    always_comb begin
        wr_prev_nxt   = host_i.write_strobe_n;
        cmd_valid_nxt = 1'b0;
        cmd_byte_nxt  = cmd_byte_r;
        if (!wr_prev_r && host_i.write_strobe_n &&
            !host_i.cmd_param_select) begin
            cmd_valid_nxt = 1'b1;
            cmd_byte_nxt  = host_i.data;
        end
    end

    // strobe history resets high so no edge is seen at release
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wr_prev_r   <= 1'b1;
            cmd_valid_r <= 1'b0;
            cmd_byte_r  <= 8'h00;
        end else begin
            wr_prev_r   <= wr_prev_nxt;
            cmd_valid_r <= cmd_valid_nxt;
            cmd_byte_r  <= cmd_byte_nxt;
        end
    end

    assign cmd_valid_o = cmd_valid_r;
    assign cmd_byte_o  = cmd_byte_r;

endmodule : sdmc_cmd_capture

// >>> core/sdmc_step_timer.sv
`timescale 1ns/1ns
module sdmc_step_timer
    import sdmc_pkg::*;
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   load_i,
    input  wire logic                   abort_i,
    input  wire logic [SEQ_TIMER_W-1:0] load_val_i,
    output logic                        done_o
);

    logic                   busy_r;
    logic                   busy_nxt;
    logic                   done_r;
    logic                   done_nxt;
    logic [SEQ_TIMER_W-1:0] cnt_r;
    logic [SEQ_TIMER_W-1:0] cnt_nxt;

    // count down from the load value; done pulses once at the end
    always_comb begin
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        cnt_nxt  = cnt_r;
        if (abort_i) begin
            busy_nxt = 1'b0;
        end else if (load_i) begin
            busy_nxt = 1'b1;
            cnt_nxt  = load_val_i;
        end else if (busy_r) begin
            if (cnt_r <= SEQ_TIMER_W'(1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - SEQ_TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r  <= '0;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign done_o = done_r;

endmodule : sdmc_step_timer

// >>> verification/sdmc_ctrl_assertions.sv
`timescale 1ns/1ns
module sdmc_ctrl_assertions
    import sdmc_pkg::*;
#(
    parameter logic [SEQ_TIMER_W-1:0] OSC_START_CYC = SEQ_OSC_START_CYC
) (
    input wire logic            sys_clk_i,
    input wire logic            resetn_i,
    input wire sdmc_host_pins_t host_i,
    input wire logic            frame_tick_i,
    input wire logic            data_oe_o,
    input wire sdmc_power_t     power_o,
    input wire logic            blank_o,
    input wire logic            show_mem_o,
    input wire logic            partial_mode_o,
    input wire logic            sleep_o,
    input wire logic            diag_run_o,
    input wire logic            dimming_en_o,
    input wire logic            mem_if_en_o
);
    logic [SEQ_TIMER_W-1:0] osc_cnt_r, osc_cnt_nxt;
    logic [1:0]             tick_cnt_r, tick_cnt_nxt;

    // cycles with oscillator up but converter still off; ticks seen in blank
    always_comb begin
        osc_cnt_nxt = '0;
        if (power_o.osc_en && !power_o.dcdc_en) begin
            osc_cnt_nxt = osc_cnt_r + 1'b1;
        end
        tick_cnt_nxt = 2'h0;
        if (blank_o) begin
            tick_cnt_nxt = tick_cnt_r +
                {1'b0, frame_tick_i && tick_cnt_r != 2'h3};
        end
    end

    // plain registers, cleared in reset so no stale count leaks across
    always_ff @(posedge sys_clk_i) begin
        osc_cnt_r  <= resetn_i ? osc_cnt_nxt : '0;
        tick_cnt_r <= resetn_i ? tick_cnt_nxt : 2'h0;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_sleep_off;
        sleep_o |-> power_o == POWER_OFF;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("power stage active while sleeping");
    property p_mem_alive;
        $past(resetn_i) |-> mem_if_en_o;
    endproperty
    a_mem_alive: assert property (p_mem_alive)
        else $error("host interface disabled out of reset");
    property p_no_dim;
        sleep_o |-> !dimming_en_o;
    endproperty
    a_no_dim: assert property (p_no_dim)
        else $error("dimming active in sleep");
    property p_reset_val;
        $rose(resetn_i) |-> sleep_o && !partial_mode_o && !diag_run_o;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("wrong state after reset");
    property p_wake;
        $fell(sleep_o) |-> power_o.osc_en && power_o.scan_en && blank_o
            && diag_run_o && !power_o.dcdc_en;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake start wrong");
    property p_osc_time;
        $rose(power_o.dcdc_en) |-> osc_cnt_r == OSC_START_CYC + 1'b1;
    endproperty
    a_osc_time: assert property (p_osc_time)
        else $error("converter start at wrong time");
    property p_offset;
        $rose(power_o.offset_charge) |-> power_o.dcdc_en && diag_run_o;
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset charge out of order");
    property p_blank;
        $fell(blank_o) && !sleep_o |-> tick_cnt_r == 2'h2;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blank not two frames");
    property p_show;
        show_mem_o |-> !blank_o && !sleep_o;
    endproperty
    a_show: assert property (p_show)
        else $error("memory shown during blank or sleep");
    property p_read;
        $rose(data_oe_o) |-> $past(host_i.read_strobe_n) == 1'b0
            && $past(host_i.cmd_param_select);
    endproperty
    a_read: assert property (p_read)
        else $error("data driven without read strobe");
endmodule : sdmc_ctrl_assertions

bind sdmc_ctrl sdmc_ctrl_assertions #(.OSC_START_CYC(OSC_START_CYC)) u_chk (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_i(host_i),
    .frame_tick_i(frame_tick_i), .data_oe_o(data_oe_o), .power_o(power_o),
    .blank_o(blank_o), .show_mem_o(show_mem_o),
    .partial_mode_o(partial_mode_o), .sleep_o(sleep_o),
    .diag_run_o(diag_run_o), .dimming_en_o(dimming_en_o),
    .mem_if_en_o(mem_if_en_o)
);

// >>> verification/sdmc_host_model.sv
`timescale 1ns/1ns
module sdmc_host_model
    import sdmc_pkg::*;
#(
    parameter int SETTLE_CYC    = 40,
    parameter int WAKE_HOLD_CYC = 100
) (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] data_i,
    input  wire logic       data_oe_i,
    output sdmc_host_pins_t host_o
);
    int         cyc_r     = 0;
    int         last_cyc  = 0;
    int         wake_cyc  = -100000;
    logic [7:0] last_code = 8'h00;

    initial host_o = '{1'b1, 1'b1, 1'b1, 8'hA5};
    // free cycle count, used to space commands
    always @(posedge sys_clk_i) cyc_r <= cyc_r + 1;

    task automatic write_cmd(input logic [7:0] code);
        // scaled waits: supplies settle before any further command
        while ((last_code == CMD_SLEEP_ENTRY || last_code == CMD_SLEEP_EXIT)
               && cyc_r - last_cyc < SETTLE_CYC) @(negedge sys_clk_i);
        while (code == CMD_SLEEP_ENTRY && cyc_r - wake_cyc < WAKE_HOLD_CYC)
            @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        host_o.cmd_param_select = 1'b0;
        host_o.data = code;
        host_o.write_strobe_n = 1'b0;
        @(negedge sys_clk_i);
        host_o.write_strobe_n = 1'b1;
        @(negedge sys_clk_i);
        host_o.data = ~code; // released bus never shows the last byte
        last_code = code;
        last_cyc = cyc_r;
        if (code == CMD_SLEEP_EXIT) wake_cyc = cyc_r;
    endtask : write_cmd

    task automatic read_byte(output logic [7:0] val, output logic oe);
        @(negedge sys_clk_i);
        host_o.cmd_param_select = 1'b1;
        host_o.read_strobe_n = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        val = data_i;
        oe = data_oe_i;
        host_o.read_strobe_n = 1'b1;
        @(negedge sys_clk_i);
    endtask : read_byte
endmodule : sdmc_host_model

// >>> verification/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import sdmc_pkg::*;
;
    logic            sys_clk_i = 1'b0;
    logic            resetn_i  = 1'b0;
    logic            tick_i    = 1'b0;
    logic            load_i    = 1'b0;
    logic            cksum_i   = 1'b0;
    logic            dim_i     = 1'b0;
    sdmc_host_pins_t host_w;
    sdmc_power_t     power_w;
    logic [7:0]      data_w, rd_v;
    logic            oe_w, blank_w, show_w, part_w, sleep_w, diag_w;
    logic            dimen_w, memen_w, rd_oe;
    int              err_total = 0;
    int              checks_done = 0;
    int              cyc = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    sdmc_ctrl #(.OSC_START_CYC(20'h8), .DCDC_START_CYC(20'hA),
        .OFFSET_CHARGE_CYC(20'h6)) dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_i(host_w),
        .frame_tick_i(tick_i), .reg_load_detect_i(load_i),
        .checksum_mismatch_i(cksum_i), .dimming_req_i(dim_i),
        .data_o(data_w), .data_oe_o(oe_w), .power_o(power_w),
        .blank_o(blank_w), .show_mem_o(show_w), .partial_mode_o(part_w),
        .sleep_o(sleep_w), .diag_run_o(diag_w), .dimming_en_o(dimen_w),
        .mem_if_en_o(memen_w));
    sdmc_host_model host (.sys_clk_i(sys_clk_i), .data_i(data_w),
        .data_oe_i(oe_w), .host_o(host_w));

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // a hang counts as a mismatch
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end

    // command, then let the answer register two edges later
    task automatic cmd(input logic [7:0] c);
        host.write_cmd(c);
        repeat (2) @(negedge sys_clk_i);
    endtask : cmd

    task automatic state_is(input logic sl, input logic pm,
                            input logic [3:0] pw);
        check("sleep", {7'h0, sleep_w}, {7'h0, sl});
        check("partial", {7'h0, part_w}, {7'h0, pm});
        check("power", {4'h0, power_w}, {4'h0, pw});
    endtask : state_is

    task automatic t_modes();
        logic [7:0] codes [4] = '{CMD_PARTIAL_ON, CMD_PARTIAL_ON,
                                  CMD_FULL_SCREEN, CMD_FULL_SCREEN};
        state_is(1'b1, 1'b0, 4'h0);
        check("mem if", {7'h0, memen_w}, 8'h01);
        cmd(CMD_SLEEP_ENTRY);
        state_is(1'b1, 1'b0, 4'h0);
        foreach (codes[i]) begin
            cmd(codes[i]);
            state_is(1'b1, i < 2, 4'h0);
        end
    endtask : t_modes

    task automatic t_wake();
        load_i = 1'b1;
        cksum_i = 1'b1;
        dim_i = 1'b1;
        cmd(CMD_SLEEP_EXIT);
        state_is(1'b0, 1'b0, 4'h9);
        check("blank", {7'h0, blank_w}, 8'h01);
        check("diag", {7'h0, diag_w}, 8'h01);
        repeat (2) begin
            @(negedge sys_clk_i) tick_i = 1'b1;
            @(negedge sys_clk_i) tick_i = 1'b0;
            repeat (3) @(negedge sys_clk_i);
        end
        check("blank end", {7'h0, blank_w}, 8'h00);
        for (int i = 0; i < 100 && diag_w !== 1'b0; i++) @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        state_is(1'b0, 1'b0, 4'hD);
        check("show", {7'h0, show_w}, 8'h01);
        check("dim awake", {7'h0, dimen_w}, 8'h01);
        cmd(CMD_SLEEP_EXIT);
        state_is(1'b0, 1'b0, 4'hD);
        check("diag again", {7'h0, diag_w}, 8'h00);
        cmd(CMD_SELF_DIAG_RD);
        host.read_byte(rd_v, rd_oe);
        check("dummy", rd_v, DUMMY_READ);
        host.read_byte(rd_v, rd_oe);
        check("diag byte", rd_v, (8'h01 << DIAG_LOAD_BIT) |
                                 (8'h01 << DIAG_CKSUM_BIT));
        host.read_byte(rd_v, rd_oe);
        check("third oe", {7'h0, rd_oe}, 8'h00);
        cmd(CMD_SLEEP_ENTRY);
        state_is(1'b1, 1'b0, 4'h0);
        check("dimming", {7'h0, dimen_w}, 8'h00);
        check("mem if", {7'h0, memen_w}, 8'h01);
    endtask : t_wake

    task automatic t_resets();
        cmd(CMD_PARTIAL_ON);
        cmd(CMD_SLEEP_EXIT);
        cmd(CMD_SW_RESET);
        state_is(1'b1, 1'b0, 4'h0);
        cmd(CMD_PARTIAL_ON);
        cmd(CMD_SLEEP_EXIT);
        resetn_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        @(negedge sys_clk_i);
        state_is(1'b1, 1'b0, 4'h0);
    endtask : t_resets

    // reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        t_modes();
        t_wake();
        t_resets();
        close_out();
    end
endmodule : tb_top
